// >>> rtl/cps_pkg.sv
// Purpose: shared constants for the charger protection selector
// Assumes: 40 MHz pclk, APB register access
// Notes: times are kept in their own units, counts derived from the clock
package cps_pkg;
	localparam int CPS_CLK_KHZ = 40000;
	localparam int CPS_QUAL_MS = 500;
	localparam int CPS_BLANK_US = 2000;
	localparam int CPS_QUAL_CYC = CPS_QUAL_MS * CPS_CLK_KHZ;
	localparam int CPS_BLANK_CYC = (CPS_BLANK_US * CPS_CLK_KHZ) / 1000;
	localparam int CPS_SYNC_STAGES = 2;
	// integrator scaling: rise per volt of switch drop, fixed decay step
	localparam int CPS_OP_RISE_PER_V = 18;
	localparam int CPS_OP_DECAY = 5;
	localparam int CPS_OP_TRIP = 20'h7D000;
	// register byte offsets
	localparam logic [7:0] CPS_CTRL_OFS = 8'h00;
	localparam logic [7:0] CPS_STATUS_OFS = 8'h04;
	localparam logic [7:0] CPS_CHG_SET_OFS = 8'h08;
	localparam logic [7:0] CPS_IN_SET_OFS = 8'h0C;
	localparam logic [7:0] CPS_OP_LVL_OFS = 8'h10;
	// control fields
	localparam int CPS_CTRL_CHG_BIT = 0;
	localparam int CPS_CTRL_LEARN_BIT = 1;
	localparam int CPS_CTRL_CELL_LO = 2;
	localparam logic [31:0] CPS_CTRL_RST = 32'h00000000;
	localparam logic [15:0] CPS_CHG_SET_RST = 16'h0000;
	localparam logic [15:0] CPS_IN_SET_RST = 16'h0000;
	// input limit cap: code for 100 mV across the input sense resistor
	localparam logic [15:0] CPS_IN_CAP = 16'h03E8;
	typedef enum {CPS_ST_ABSENT, CPS_ST_QUAL, CPS_ST_GOOD, CPS_ST_BATOFF,
		CPS_ST_ADAPTER} cps_state_t;
endpackage : cps_pkg

// >>> rtl/cps_selector.sv
// Purpose: protection and power-path supervisor for a battery charger
// Assumes: comparator results arrive asynchronously; APB slave, no waits
// Notes: switch drives are break-before-make, faults override selection
`timescale 1ns/1ps
`default_nettype none
module cps_selector
	import cps_pkg::*;
#(
	parameter int QUAL_CYC = cps_pkg::CPS_QUAL_CYC,
	parameter int BLANK_CYC = cps_pkg::CPS_BLANK_CYC,
	parameter int CODE_W = 16,
	parameter int RATE_W = 8,
	parameter int ACC_W = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// comparator results, asynchronous
	input wire logic supply_ok_cmp,
	input wire logic adapter_present_cmp,
	input wire logic adapter_detect_in,
	input wire logic overvoltage_set_in,
	input wire logic sync_threshold_cmp,
	input wire logic battery_ov_high_cmp,
	input wire logic battery_ov_low_cmp,
	input wire logic battery_short_cmp,
	input wire logic charge_overcurrent_cmp,
	input wire logic temp_high_cmp,
	input wire logic temp_low_cmp,
	input wire logic input_current_limit,
	input wire logic [RATE_W-1:0] switch_drop_code,
	// power path and converter controls
	output logic adapter_switch_drive,
	output logic battery_switch_drive,
	output logic charge_enable,
	output logic high_side_enable,
	output logic sync_mode,
	output logic discharge_sink_en,
	output logic internal_regulator_en,
	output logic input_current_monitor_en,
	output logic [1:0] cell_count,
	output logic [CODE_W-1:0] charge_current_code,
	output logic [CODE_W-1:0] input_limit_code,
	// open-drain adapter ok
	output logic adapter_ok_n_o,
	output logic adapter_ok_n_oe_n
);
	import cps_pkg::*;
	localparam int NSYNC = 12;
	localparam int S_SUP = 0, S_PRES = 1, S_DET = 2, S_OVP = 3, S_SYN = 4;
	localparam int S_BOVH = 5, S_BOVL = 6, S_BSH = 7, S_OC = 8, S_TH = 9;
	localparam int S_TL = 10, S_LIM = 11;
	function automatic logic in_map(input logic [31:0] a);
		in_map = (a == 32'(CPS_CTRL_OFS)) || (a == 32'(CPS_STATUS_OFS)) ||
			(a == 32'(CPS_CHG_SET_OFS)) || (a == 32'(CPS_IN_SET_OFS)) ||
			(a == 32'(CPS_OP_LVL_OFS));
	endfunction : in_map
	//------------------------------------------------------------
	// input synchronisers
	//------------------------------------------------------------
	logic [NSYNC-1:0] raw_in, meta_r, sync_r;
	logic [RATE_W-1:0] drop_meta_r, drop_r;
	assign raw_in = {input_current_limit, temp_low_cmp, temp_high_cmp,
		charge_overcurrent_cmp, battery_short_cmp, battery_ov_low_cmp,
		battery_ov_high_cmp, sync_threshold_cmp, overvoltage_set_in,
		adapter_detect_in, adapter_present_cmp, supply_ok_cmp};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= raw_in[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate
	// drop code is a slow analogue reading; per-bit skew only costs a step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drop_meta_r <= '0;
			drop_r <= '0;
		end else begin
			drop_meta_r <= switch_drop_code;
			drop_r <= drop_meta_r;
		end
	end
	logic sup_ok, det_ok, ovp;
	assign sup_ok = sync_r[S_SUP];
	assign det_ok = sync_r[S_DET];
	assign ovp = sync_r[S_OVP];
	//------------------------------------------------------------
	// apb registers
	//------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [CODE_W-1:0] chg_set_r;
	logic [CODE_W-1:0] in_set_r;
	logic [ACC_W-1:0] op_acc_r;
	logic [31:0] status;
	logic wr_en, learn, chg_req;
	assign wr_en = psel && penable && pwrite;
	assign learn = ctrl_r[CPS_CTRL_LEARN_BIT];
	assign chg_req = ctrl_r[CPS_CTRL_CHG_BIT];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !in_map(paddr);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CPS_CTRL_RST;
			chg_set_r <= CPS_CHG_SET_RST;
			in_set_r <= CPS_IN_SET_RST;
		end else if (wr_en) begin
			if (paddr == 32'(CPS_CTRL_OFS)) begin
				ctrl_r <= {28'h0000000, pwdata[3:0]};
			end
			if (paddr == 32'(CPS_CHG_SET_OFS)) begin
				chg_set_r <= pwdata[CODE_W-1:0];
			end
			if (paddr == 32'(CPS_IN_SET_OFS)) begin
				in_set_r <= pwdata[CODE_W-1:0];
			end
		end
	end
	always_comb begin
		prdata = 32'h00000000;
		if (psel && !pwrite) begin
			case (paddr)
				32'(CPS_CTRL_OFS): prdata = ctrl_r;
				32'(CPS_STATUS_OFS): prdata = status;
				32'(CPS_CHG_SET_OFS): prdata = 32'(chg_set_r);
				32'(CPS_IN_SET_OFS): prdata = 32'(in_set_r);
				32'(CPS_OP_LVL_OFS): prdata = 32'(op_acc_r);
				default: prdata = 32'h00000000;
			endcase
		end
	end
	//------------------------------------------------------------
	// adapter qualification sequence
	//------------------------------------------------------------
	cps_state_t st_r;
	logic [31:0] qual_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= CPS_ST_ABSENT;
			qual_cnt_r <= '0;
		end else if (!sup_ok || !det_ok) begin
			st_r <= CPS_ST_ABSENT;
			qual_cnt_r <= '0;
		end else begin
			case (st_r)
				CPS_ST_ABSENT: begin
					st_r <= CPS_ST_QUAL;
					qual_cnt_r <= '0;
				end
				CPS_ST_QUAL: begin
					if (qual_cnt_r >= 32'(QUAL_CYC - 1)) begin
						st_r <= CPS_ST_GOOD;
					end else begin
						qual_cnt_r <= qual_cnt_r + 32'h00000001;
					end
				end
				CPS_ST_GOOD: st_r <= CPS_ST_BATOFF;
				CPS_ST_BATOFF: st_r <= CPS_ST_ADAPTER;
				CPS_ST_ADAPTER: st_r <= CPS_ST_ADAPTER;
				default: st_r <= CPS_ST_ABSENT;
			endcase
		end
	end
	logic ok_active;
	assign ok_active = (st_r == CPS_ST_GOOD) || (st_r == CPS_ST_BATOFF) ||
		(st_r == CPS_ST_ADAPTER);
	assign adapter_ok_n_o = 1'b0;
	assign adapter_ok_n_oe_n = !ok_active;
	//------------------------------------------------------------
	// over-power integrator and latch
	//------------------------------------------------------------
	logic [31:0] blank_cnt_r;
	logic blank_done;
	logic op_latch_r;
	logic det_d_r, sup_d_r;
	logic op_clear;
	logic [ACC_W:0] acc_up;
	logic [ACC_W-1:0] acc_nxt;
	assign blank_done = blank_cnt_r >= 32'(BLANK_CYC);
	assign op_clear = (det_ok && !det_d_r) || (sup_ok && !sup_d_r);
	assign acc_up = {1'b0, op_acc_r} +
		(ACC_W+1)'(drop_r * CPS_OP_RISE_PER_V);
	always_comb begin
		acc_nxt = op_acc_r;
		if (sync_r[S_LIM]) begin
			// saturate rather than wrap
			acc_nxt = acc_up[ACC_W] ? '1 : acc_up[ACC_W-1:0];
		end else if (op_acc_r > ACC_W'(CPS_OP_DECAY)) begin
			acc_nxt = op_acc_r - ACC_W'(CPS_OP_DECAY);
		end else begin
			acc_nxt = '0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_acc_r <= '0;
		end else begin
			op_acc_r <= acc_nxt;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_cnt_r <= '0;
		end else if (!adapter_switch_drive) begin
			blank_cnt_r <= '0;
		end else if (!blank_done) begin
			blank_cnt_r <= blank_cnt_r + 32'h00000001;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_d_r <= 1'b0;
			sup_d_r <= 1'b0;
			op_latch_r <= 1'b0;
		end else begin
			det_d_r <= det_ok;
			sup_d_r <= sup_ok;
			// set wins over clear
			if (blank_done && adapter_switch_drive &&
				op_acc_r > ACC_W'(CPS_OP_TRIP)) begin
				op_latch_r <= 1'b1;
			end else if (op_clear) begin
				op_latch_r <= 1'b0;
			end
		end
	end
	//------------------------------------------------------------
	// converter protections
	//------------------------------------------------------------
	logic bov_r, therm_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bov_r <= 1'b0;
			therm_r <= 1'b0;
		end else begin
			if (sync_r[S_BOVH]) begin
				bov_r <= 1'b1;
			end else if (!sync_r[S_BOVL]) begin
				bov_r <= 1'b0;
			end
			if (sync_r[S_TH]) begin
				therm_r <= 1'b1;
			end else if (!sync_r[S_TL]) begin
				therm_r <= 1'b0;
			end
		end
	end
	//------------------------------------------------------------
	// power path selection and outputs
	//------------------------------------------------------------
	logic bshort, fault;
	logic want_ad, want_bat, chg_nxt;
	assign bshort = sync_r[S_BSH];
	assign fault = ovp || op_latch_r;
	always_comb begin
		want_ad = 1'b0;
		want_bat = 1'b1;
		if (!sup_ok) begin
			want_ad = 1'b0;
			want_bat = 1'b0;
		end else if (fault) begin
			want_ad = 1'b0;
			want_bat = 1'b1;
		end else if (st_r == CPS_ST_BATOFF) begin
			want_bat = 1'b0;
		end else if (st_r == CPS_ST_ADAPTER) begin
			if (learn && !bshort) begin
				want_ad = 1'b0;
				want_bat = 1'b1;
			end else begin
				want_ad = 1'b1;
				want_bat = 1'b0;
			end
		end
	end
	assign chg_nxt = chg_req && sup_ok && !fault && !learn && !therm_r &&
		(st_r == CPS_ST_ADAPTER);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adapter_switch_drive <= 1'b0;
			battery_switch_drive <= 1'b0;
			charge_enable <= 1'b0;
			discharge_sink_en <= 1'b0;
			high_side_enable <= 1'b0;
			sync_mode <= 1'b0;
		end else begin
			// break-before-make between the two drives
			adapter_switch_drive <= want_ad && !battery_switch_drive;
			battery_switch_drive <= want_bat && !adapter_switch_drive;
			charge_enable <= chg_nxt;
			discharge_sink_en <= chg_nxt;
			high_side_enable <= chg_nxt && !bov_r && !sync_r[S_BOVH] &&
				!sync_r[S_OC];
			sync_mode <= chg_nxt && sync_r[S_SYN];
		end
	end
	logic [CODE_W+1:0] in_lim;
	assign in_lim = {2'b00, in_set_r} + {3'b000, in_set_r[CODE_W-1:1]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_regulator_en <= 1'b0;
			input_current_monitor_en <= 1'b0;
			charge_current_code <= '0;
			input_limit_code <= '0;
			cell_count <= 2'b00;
		end else begin
			internal_regulator_en <= sup_ok;
			input_current_monitor_en <= sup_ok && sync_r[S_PRES];
			charge_current_code <= bshort ? (chg_set_r >> 3) : chg_set_r;
			input_limit_code <= (in_lim > (CODE_W+2)'(CPS_IN_CAP)) ?
				CODE_W'(CPS_IN_CAP) : in_lim[CODE_W-1:0];
			cell_count <= ctrl_r[CPS_CTRL_CELL_LO+1:CPS_CTRL_CELL_LO];
		end
	end
	assign status = {21'h000000, bshort, therm_r, bov_r, op_latch_r, ovp,
		ok_active, sup_ok, det_ok, charge_enable, battery_switch_drive,
		adapter_switch_drive};
	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	drives_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(adapter_switch_drive && battery_switch_drive))
		else $error("both switch drives on");
	ovp_response_a: assert property (@(posedge pclk) disable iff (!presetn)
		ovp |=> !adapter_switch_drive && !charge_enable ##1
		(battery_switch_drive || !sup_ok || $past(!ovp)))
		else $error("overvoltage response wrong");
	lockout_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!sup_ok |=> !internal_regulator_en && !adapter_switch_drive &&
		!battery_switch_drive)
		else $error("lockout left bias on");
	short_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
		bshort |=> charge_current_code == ($past(chg_set_r) >> 3))
		else $error("short current not one eighth");
	therm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		therm_r && sync_r[S_TL] |=> therm_r && !charge_enable)
		else $error("thermal released early");
	op_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(op_latch_r) |-> $past(blank_done) && $past(adapter_switch_drive))
		else $error("latch set in blanking");
	op_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		op_latch_r && !op_clear |=> op_latch_r)
		else $error("latch cleared without cause");
	seq_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(adapter_switch_drive) |-> !adapter_ok_n_oe_n &&
		$past(!battery_switch_drive, 1) && $past(!adapter_ok_n_oe_n, 2))
		else $error("adapter switch order wrong");
	hs_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		bov_r |=> !high_side_enable)
		else $error("high side on in overvoltage");
	sync_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		sync_mode |-> charge_enable && discharge_sink_en && $past(sync_r[S_SYN]))
		else $error("sync mode without threshold");
endmodule : cps_selector
`default_nettype wire

// >>> tb/cps_power_model.sv
// Purpose: far-side model of the power switches and the status pull-up
// Assumes: the bench requests an input surge through one control line
// Notes: current limiting happens only while the adapter switch is on
`timescale 1ns/1ps
`default_nettype none
module cps_power_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// drives from the selector
	input wire logic adapter_switch_drive,
	input wire logic battery_switch_drive,
	input wire logic adapter_ok_n_o,
	input wire logic adapter_ok_n_oe_n,
	// bench control
	input wire logic surge,
	// back to the selector and host
	output logic input_current_limit,
	output logic [7:0] switch_drop_code,
	output logic adapter_ok_wire,
	output logic both_on_seen
);
	// pull-up wins while the pin is released
	assign adapter_ok_wire = adapter_ok_n_oe_n ? 1'b1 : adapter_ok_n_o;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_current_limit <= 1'b0;
			switch_drop_code <= 8'h00;
			both_on_seen <= 1'b0;
		end else begin
			input_current_limit <= surge & adapter_switch_drive;
			switch_drop_code <= (surge & adapter_switch_drive) ? 8'hFF : 8'h01;
			if (adapter_switch_drive & battery_switch_drive) begin
				both_on_seen <= 1'b1;
			end
		end
	end
endmodule : cps_power_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the charger protection selector
// Assumes: short qualification and blanking counts
// Notes: comparator inputs change just after rising edges
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cps_pkg::*;
	localparam int QUAL = 20;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, surge = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e;
	logic sup = 1'b0, apres = 1'b0, det = 1'b0, ovp = 1'b0, syn = 1'b0;
	logic bovh = 1'b0, bovl = 1'b0, shrt = 1'b0, oc = 1'b0, th = 1'b0;
	logic tl = 1'b0, lim, both;
	logic [7:0] drop;
	logic adp, bat, chg, hs, sm, dis, reg_en, mon, ok_o, ok_oe_n, ok_w;
	logic [1:0] cells;
	logic [15:0] ccode, icode;
	int n_mismatch = 0, check_count = 0, n;
	logic [31:0] q1;
	cps_selector #(.QUAL_CYC(QUAL), .BLANK_CYC(10)) cps_selector_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .supply_ok_cmp(sup),
		.adapter_present_cmp(apres), .adapter_detect_in(det),
		.overvoltage_set_in(ovp), .sync_threshold_cmp(syn),
		.battery_ov_high_cmp(bovh), .battery_ov_low_cmp(bovl),
		.battery_short_cmp(shrt), .charge_overcurrent_cmp(oc),
		.temp_high_cmp(th), .temp_low_cmp(tl), .input_current_limit(lim),
		.switch_drop_code(drop), .adapter_switch_drive(adp),
		.battery_switch_drive(bat), .charge_enable(chg),
		.high_side_enable(hs), .sync_mode(sm), .discharge_sink_en(dis),
		.internal_regulator_en(reg_en), .input_current_monitor_en(mon),
		.cell_count(cells), .charge_current_code(ccode),
		.input_limit_code(icode), .adapter_ok_n_o(ok_o),
		.adapter_ok_n_oe_n(ok_oe_n));
	cps_power_model cps_power_model_i (
		.pclk(pclk), .presetn(presetn), .adapter_switch_drive(adp),
		.battery_switch_drive(bat), .adapter_ok_n_o(ok_o),
		.adapter_ok_n_oe_n(ok_oe_n), .surge(surge),
		.input_current_limit(lim), .switch_drop_code(drop),
		.adapter_ok_wire(ok_w), .both_on_seen(both));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	task automatic step(input int k);
		repeat (k) @(posedge pclk);
	endtask : step
	task automatic chk(input string nm, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic sig(input int k);
		case (k)
			0: sig = ok_w;
			1: sig = bat;
			2: sig = adp;
			default: sig = hs;
		endcase
	endfunction : sig
	task automatic wt(input string nm, input int k, input logic v);
		for (n = 0; n < 300 && sig(k) !== v; n++) step(1);
		chk(nm, sig(k), v);
	endtask : wt
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	initial begin
		#(25 * 20000);
		n_mismatch++;
		close_out();
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		step(2);
		chk("ok_rst", ok_w, 1'b1);
		chk("adp_rst", adp, 1'b0);
		presetn <= 1'b1;
		apb(0, CPS_CTRL_OFS, 0);
		chk("ctrl_rst", q, CPS_CTRL_RST);
		apb(1, 8'h20, 32'h5);
		chk("unmapped", e, 1'b1);
		step(6);
		chk("reg_off", reg_en, 1'b0);
		chk("bat_nosup", bat, 1'b0);
		sup <= 1'b1;
		step(6);
		chk("reg_on", reg_en, 1'b1);
		chk("bat_noad", bat, 1'b1);
		chk("adp_noad", adp, 1'b0);
		chk("mon_off", mon, 1'b0);
		apres <= 1'b1;
		step(6);
		chk("mon_on", mon, 1'b1);
		apb(1, CPS_CHG_SET_OFS, 32'h100);
		apb(1, CPS_IN_SET_OFS, 32'h100);
		step(4);
		chk("ccode", ccode, 16'h0100);
		chk("icode", icode, 16'h0180);
		apb(1, CPS_IN_SET_OFS, 32'h1000);
		apb(1, CPS_CTRL_OFS, 32'h9);
		step(4);
		chk("icap", icode, CPS_IN_CAP);
		chk("cells", cells, 2'b10);
		det <= 1'b1;
		for (n = 0; n < 100 && ok_w !== 1'b0; n++) step(1);
		chk("qual", n >= QUAL && n <= QUAL + 6, 1'b1);
		chk("adp_late", adp, 1'b0);
		wt("bat_off", 1, 1'b0);
		chk("adp_after", adp, 1'b0);
		wt("adp_on", 2, 1'b1);
		step(4);
		chk("chg_on", chg, 1'b1);
		chk("sink_on", dis, 1'b1);
		shrt <= 1'b1;
		step(6);
		chk("c_div8", ccode, 16'h0020);
		apb(0, CPS_STATUS_OFS, 0);
		chk("short_flag", q[10], 1'b1);
		shrt <= 1'b0;
		step(6);
		chk("c_full", ccode, 16'h0100);
		syn <= 1'b1;
		step(6);
		chk("sync_hi", sm, 1'b1);
		syn <= 1'b0;
		step(6);
		chk("sync_lo", sm, 1'b0);
		chk("hs_base", hs, 1'b1);
		bovh <= 1'b1;
		bovl <= 1'b1;
		th <= 1'b1;
		tl <= 1'b1;
		step(6);
		chk("hs_ov", hs, 1'b0);
		bovh <= 1'b0;
		th <= 1'b0;
		step(6);
		chk("hs_hold", hs, 1'b0);
		bovl <= 1'b0;
		tl <= 1'b0;
		wt("hs_back", 3, 1'b1);
		oc <= 1'b1;
		step(6);
		chk("hs_oc", hs, 1'b0);
		oc <= 1'b0;
		wt("hs_oc_back", 3, 1'b1);
		apb(1, CPS_CTRL_OFS, 32'h8);
		step(6);
		chk("sink_off", dis, 1'b0);
		apb(1, CPS_CTRL_OFS, 32'h9);
		ovp <= 1'b1;
		step(6);
		chk("ovp_adp", adp, 1'b0);
		chk("ovp_bat", bat, 1'b1);
		chk("ovp_chg", chg, 1'b0);
		ovp <= 1'b0;
		wt("ovp_back", 2, 1'b1);
		apb(1, CPS_CTRL_OFS, 32'hB);
		wt("lrn_bat", 1, 1'b1);
		chk("lrn_adp", adp, 1'b0);
		chk("lrn_chg", chg, 1'b0);
		shrt <= 1'b1;
		wt("lrn_short", 2, 1'b1);
		chk("lrn_sbat", bat, 1'b0);
		shrt <= 1'b0;
		wt("lrn_rec", 1, 1'b1);
		chk("lrn_radp", adp, 1'b0);
		apb(1, CPS_CTRL_OFS, 32'h9);
		wt("lrn_exit", 2, 1'b1);
		surge <= 1'b1;
		step(10);
		apb(0, CPS_OP_LVL_OFS, 0);
		chk("op_rise", q != 0, 1'b1);
		surge <= 1'b0;
		// let the limit flag drain through the synchroniser first
		step(6);
		apb(0, CPS_OP_LVL_OFS, 0);
		q1 = q;
		step(10);
		apb(0, CPS_OP_LVL_OFS, 0);
		// 13 edges lie between the two samples
		chk("op_decay", q1 - q, 32'(13 * CPS_OP_DECAY));
		surge <= 1'b1;
		wt("op_trip", 2, 1'b0);
		wt("op_bat", 1, 1'b1);
		chk("op_chg", chg, 1'b0);
		surge <= 1'b0;
		step(QUAL + 10);
		apb(0, CPS_STATUS_OFS, 0);
		chk("op_latch", q[7], 1'b1);
		chk("op_held", adp, 1'b0);
		det <= 1'b0;
		step(6);
		det <= 1'b1;
		step(6);
		apb(0, CPS_STATUS_OFS, 0);
		chk("op_clear", q[7], 1'b0);
		wt("op_reconn", 2, 1'b1);
		chk("both_on", both, 1'b0);
		close_out();
	end
endmodule : testbench
`default_nettype wire
